// File: common/cvt_pkg.sv
package cvt_pkg;
    // Sample and slot geometry
    localparam int SAMPLE_W = 24;
    localparam int PAIR_W = 2 * SAMPLE_W;
    localparam int FIFO_DEPTH = 4;
    // Bit clock watchdog; a longest wait rounds down
    localparam int CLK_MHZ = 125;
    localparam int BCLK_LOSS_NS = 4000;
    localparam logic [8:0] BCLK_LOSS_CYC = 9'((BCLK_LOSS_NS * CLK_MHZ) / 1000);
    // Frame sync missing once this many bit clocks pass
    localparam logic [9:0] FS_LOSS_BITS = 10'h3FF;
    localparam logic [4:0] START_FRAMES = 5'h10;
    localparam logic [4:0] RELOCK_FRAMES = 5'h04;
    localparam logic [5:0] MUTE_FRAMES = 6'h30;
    localparam logic [5:0] DECIM_LAST = 6'h3F;
    localparam logic [4:0] PAD_FIRST = 5'h18;
    // Decoded slot strap levels
    localparam logic [2:0] STRAP_I2S = 3'h0;
    localparam logic [2:0] STRAP_S12 = 3'h1;
    localparam logic [2:0] STRAP_S34 = 3'h2;
    localparam logic [2:0] STRAP_S56 = 3'h3;
    localparam logic [2:0] STRAP_S78 = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOCK = 2'b01,
        ST_RUN = 2'b10
    } conv_state_e;

    typedef struct packed {
        logic [SAMPLE_W-1:0] ch1;
        logic [SAMPLE_W-1:0] ch0;
    } pair_s;

    typedef struct packed {
        logic [2:0] bclk_p;
        logic [1:0] fs_p;
        logic [1:0] dat_p;
        logic [2:0] strap_m;
        logic [2:0] strap_s;
        logic [1:0] strap_cnt;
        logic [2:0] strap;
        conv_state_e state;
        logic first;
        logic fs_last;
        logic [9:0] bits;
        logic [3:0] k;
        logic [3:0] k_meas;
        logic [4:0] lock_cnt;
        logic [5:0] mute;
        logic [8:0] loss;
        logic [9:0] pos;
        logic [9:0] obit;
        logic half;
        logic [3:0] div;
        logic mic_clk;
        logic [5:0] dec;
        logic [6:0] acc0;
        logic [6:0] acc1;
        logic push_v;
        pair_s push_d;
        pair_s tx;
        logic sd;
        logic sd_oe;
    } conv_s;

    // Bit clocks per frame minus one, to mic clock divide
    function automatic logic [3:0] ratio_k(input logic [9:0] b);
        case (b)
            10'h03F: ratio_k = 4'h1;
            10'h07F: ratio_k = 4'h2;
            10'h0BF: ratio_k = 4'h3;
            10'h0FF: ratio_k = 4'h4;
            10'h17F: ratio_k = 4'h6;
            10'h1FF: ratio_k = 4'h8;
            default: ratio_k = 4'h0;
        endcase
    endfunction

    // Ones count of 64 bits to signed 24-bit, full scale saturates
    function automatic logic [23:0] to_pcm(input logic [6:0] c);
        to_pcm = c[6] ? 24'h7FFFFF : {~c[5], c[4:0], 18'h00000};
    endfunction

    // MSB first, zero pad after the sample
    function automatic logic pick_bit(input pair_s w, input logic ch, input logic [4:0] b);
        logic [23:0] v;
        v = ch ? w.ch1 : w.ch0;
        pick_bit = (b < PAD_FIRST) ? v[5'h17 - b] : 1'b0;
    endfunction
endpackage

// File: rtl/pdm_tdm_converter.sv
// What this block does
// [RULE1] Decimate each channel 64 to 1 from one bit into 24-bit samples.
// [RULE2] Falling mic clock bits feed channel 0, rising ones channel 1.
// [RULE3] After power-up wait 16 full frames before driving the mic clock.
// [RULE4] Hold serial output quiet a further 48 frames after mic clock starts.
// [RULE5] Losing bit clock or frame sync stops mic clock at once; idle.
// [RULE6] On clock return relock and restart mic clock after about 4 frames.
// [RULE7] Format change seen at frame end stops, reconfigures, restarts by itself.
// [RULE8] Host gives 64,128,192,256,384 or 512 bit clocks; ratio found automatically.
// [RULE9] Mic clock runs at exactly 64 times the frame rate.
// [RULE10] Host keeps frame rate between 4 kHz and 96 kHz.
// [RULE11] All filtering runs at the mic clock rate.
// [RULE12] Ratio 64 means two-slot I2S; larger ratios give 4 to 16 slots.
// [RULE13] Data only ever placed in the first eight slots.
// [RULE14] Strap chooses I2S or slot pair 1-2, 3-4, 5-6, 7-8; 32-bit slots. Code takes I2S from ratio 64 alone; strap I2S level sends slots 1-2.
// [RULE15] Slot choice ignores slot count; unreachable slots are not sent.
// [RULE16] Serial output released except while sending channel data.
// [RULE17] I2S frame starts at sync fall; channel 1 follows sync rise.
// [RULE18] Host keeps I2S frame sync at 50 percent duty.
// [RULE19] Host gives exactly 64 bit clocks per I2S frame.
// [RULE20] TDM frame sync is a positive pulse; frame starts at its rise.
// [RULE21] Sync sampled on bit clock rise, data changed on bit clock fall.
// [RULE22] Mic data captured on both mic clock edges.
// [RULE23] 24-bit sample sent MSB first from slot bit 0, rest zeros.
// [RULE24] I2S MSB starts one bit clock after the sync edge.
`timescale 1ns/100ps
module sample_fifo #(
    parameter int W = cvt_pkg::PAIR_W,
    parameter int DEPTH = cvt_pkg::FIFO_DEPTH
) (
    input logic clock,
    input logic sys_rst,
    input logic in_valid,
    output logic in_ready,
    input logic [W-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } fifo_s;
    fifo_s f_r;
    fifo_s f_nxt;
    logic wr_en;
    logic rd_en;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // Flags straight from the occupancy count
    assign in_ready = f_r.cnt != (AW+1)'(DEPTH);
    assign out_valid = f_r.cnt != '0;
    assign out_data = f_r.mem[f_r.rd];
    assign wr_en = in_valid & in_ready;
    assign rd_en = out_ready & out_valid;

    // Pointer and count update
    always_comb
    begin
        f_nxt = f_r;
        if (wr_en)
        begin
            f_nxt.mem[f_r.wr] = in_data;
            f_nxt.wr = step(f_r.wr);
        end
        if (rd_en)
            f_nxt.rd = step(f_r.rd);
        f_nxt.cnt = f_r.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            f_r <= '0;
        else
            f_r <= f_nxt;
    end
endmodule

module pdm_tdm_converter (
    input logic clock,
    input logic sys_rst,
    input logic bit_clock,
    input logic frame_sync,
    input logic mic_density_input,
    input logic [2:0] slot_strap,
    output logic mic_clock_output,
    output logic serial_audio_out,
    output logic serial_audio_oe
);
    cvt_pkg::conv_s st_r;
    cvt_pkg::conv_s st_nxt;
    cvt_pkg::pair_s fifo_dout;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic pop;
    logic br;
    logic bf;
    logic fs;
    logic fs_rise;
    logic i2s;
    logic lost;
    logic run;
    logic live;
    logic [3:0] km;
    logic [4:0] need;
    logic [1:0] pair;

    // [RULE21] Bit clock edges
    assign br = st_r.bclk_p[1] & ~st_r.bclk_p[2];
    assign bf = ~st_r.bclk_p[1] & st_r.bclk_p[2];
    assign fs = st_r.fs_p[1];
    // [RULE20] Pulse rise starts frame
    assign fs_rise = fs & ~st_r.fs_last;
    // [RULE8] Ratio from frame length
    assign km = cvt_pkg::ratio_k(st_r.bits);
    // [RULE12] Ratio 64 is I2S
    assign i2s = st_r.k == 4'h1;
    assign lost = (st_r.loss == cvt_pkg::BCLK_LOSS_CYC) | (st_r.bits == cvt_pkg::FS_LOSS_BITS);
    assign run = st_r.state == cvt_pkg::ST_RUN;
    assign live = run & (st_r.mute == 6'h00);
    assign need = st_r.first ? cvt_pkg::START_FRAMES : cvt_pkg::RELOCK_FRAMES;
    // [RULE14] Strap to slot pair
    assign pair = (st_r.strap == cvt_pkg::STRAP_I2S) ? 2'h0 : 2'(st_r.strap - 3'h1);

    assign mic_clock_output = st_r.mic_clk;
    assign serial_audio_out = st_r.sd;
    assign serial_audio_oe = st_r.sd_oe;

    // Decouples decimation from frame starts; drained while muted
    sample_fifo #(
        .W(cvt_pkg::PAIR_W),
        .DEPTH(cvt_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(st_r.push_v),
        .in_ready(fifo_in_ready),
        .in_data(st_r.push_d),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_dout)
    );

    // Whole converter next state
    always_comb
    begin
        logic dat;
        logic en;
        logic [6:0] a1;
        dat = st_r.dat_p[1];
        en = 1'b0;
        a1 = st_r.acc1 + {6'h00, dat};
        st_nxt = st_r;
        // [RULE4] Drain while muted, so no stale pair leads after relock
        pop = run & (st_r.mute != 6'h00) & fifo_out_valid;
        // Pins pass two flops; third bit clock stage only for edges
        st_nxt.bclk_p = {st_r.bclk_p[1:0], bit_clock};
        st_nxt.fs_p = {st_r.fs_p[0], frame_sync};
        st_nxt.dat_p = {st_r.dat_p[0], mic_density_input};
        st_nxt.strap_m = slot_strap;
        st_nxt.strap_s = st_r.strap_m;
        // Strap caught once, after the synchroniser has filled
        if (st_r.strap_cnt != 2'h3)
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
        if (st_r.strap_cnt == 2'h2)
            st_nxt.strap = st_r.strap_s;
        // Watchdog restarts on any bit clock edge
        if (br | bf)
            st_nxt.loss = 9'h000;
        else if (st_r.loss != cvt_pkg::BCLK_LOSS_CYC)
            st_nxt.loss = st_r.loss + 9'h001;
        if (st_r.push_v && fifo_in_ready)
            st_nxt.push_v = 1'b0;

        // [RULE9] Mic clock from bit clock
        if (run && (br || bf))
        begin
            if (st_r.div == st_r.k - 4'h1)
            begin
                st_nxt.div = 4'h0;
                st_nxt.mic_clk = ~st_r.mic_clk;
                // [RULE22] Both edges captured
                if (st_r.mic_clk)
                begin
                    // [RULE2] Falling feeds channel 0
                    st_nxt.acc0 = st_r.acc0 + {6'h00, dat};
                end
                else
                begin
                    // [RULE11] Filter at mic rate
                    st_nxt.acc1 = a1;
                    st_nxt.dec = st_r.dec + 6'h01;
                    // [RULE1] 64 to 1 decimation
                    if (st_r.dec == cvt_pkg::DECIM_LAST)
                    begin
                        // A stalled pair is kept; one leaving this cycle makes room
                        if (!st_r.push_v || fifo_in_ready)
                        begin
                            st_nxt.push_v = 1'b1;
                            st_nxt.push_d.ch1 = cvt_pkg::to_pcm(a1);
                            st_nxt.push_d.ch0 = cvt_pkg::to_pcm(st_r.acc0);
                        end
                        st_nxt.acc0 = 7'h00;
                        st_nxt.acc1 = 7'h00;
                    end
                end
            end
            else
                st_nxt.div = st_r.div + 4'h1;
        end

        // [RULE21] Sync sampled on rise
        if (br)
        begin
            st_nxt.fs_last = fs;
            if (fs_rise)
                st_nxt.bits = 10'h000;
            else if (st_r.bits != cvt_pkg::FS_LOSS_BITS)
                st_nxt.bits = st_r.bits + 10'h001;
            if (fs_rise)
            begin
                st_nxt.k_meas = km;
                case (st_r.state)
                    cvt_pkg::ST_IDLE:
                    begin
                        st_nxt.state = cvt_pkg::ST_LOCK;
                        st_nxt.lock_cnt = 5'h00;
                    end
                    cvt_pkg::ST_LOCK:
                    begin
                        // [RULE3] Count stable frames
                        if (km != 4'h0 && km == st_r.k_meas)
                        begin
                            st_nxt.lock_cnt = st_r.lock_cnt + 5'h01;
                            // [RULE6] Shorter relock wait
                            if (st_r.lock_cnt + 5'h01 == need)
                            begin
                                st_nxt.state = cvt_pkg::ST_RUN;
                                st_nxt.k = km;
                                st_nxt.mute = cvt_pkg::MUTE_FRAMES;
                                st_nxt.first = 1'b0;
                                st_nxt.div = 4'h0;
                                st_nxt.dec = 6'h00;
                                st_nxt.acc0 = 7'h00;
                                st_nxt.acc1 = 7'h00;
                            end
                        end
                        else
                            st_nxt.lock_cnt = 5'h00;
                    end
                    cvt_pkg::ST_RUN:
                    begin
                        // [RULE7] Format change relock
                        if (km != st_r.k)
                        begin
                            st_nxt.state = cvt_pkg::ST_LOCK;
                            st_nxt.lock_cnt = 5'h00;
                            st_nxt.mic_clk = 1'b0;
                            st_nxt.sd_oe = 1'b0;
                            st_nxt.sd = 1'b0;
                        end
                        // [RULE4] Mute frame countdown
                        else if (st_r.mute != 6'h00)
                            st_nxt.mute = st_r.mute - 6'h01;
                    end
                    default:
                        st_nxt.state = cvt_pkg::ST_IDLE;
                endcase
            end
            // [RULE17] I2S uses both edges
            if (i2s ? (fs != st_r.fs_last) : fs_rise)
            begin
                st_nxt.pos = 10'h000;
                st_nxt.half = fs;
                // New pair only at the frame start, never mid-frame
                if (live && !(i2s && fs))
                begin
                    pop = fifo_out_valid;
                    if (fifo_out_valid)
                        st_nxt.tx = fifo_dout;
                end
            end
            else if (st_r.pos != 10'h3FF)
                st_nxt.pos = st_r.pos + 10'h001;
        end

        // [RULE24] Bit 0 after frame edge
        if (bf && run)
        begin
            // [RULE13] [RULE15] Fixed first-eight slots
            if (i2s)
                en = st_r.pos[9:5] == 5'h00;
            else
                en = st_r.pos[9:8] == 2'h0 && st_r.pos[7:6] == pair;
            // [RULE16] Drive only own bits
            en = en & live;
            st_nxt.sd_oe = en;
            // [RULE23] MSB first, zero pad
            st_nxt.sd = en & cvt_pkg::pick_bit(st_r.tx, i2s ? st_r.half : st_r.pos[5],
                st_r.pos[4:0]);
            st_nxt.obit = st_r.pos;
        end

        // [RULE5] Clock loss stops all
        if (lost && st_r.state != cvt_pkg::ST_IDLE)
        begin
            st_nxt.state = cvt_pkg::ST_IDLE;
            st_nxt.mic_clk = 1'b0;
            st_nxt.sd_oe = 1'b0;
            st_nxt.sd = 1'b0;
        end
    end

    // State register; first power-up uses the long start wait
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.first <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_lost;
        lost && st_r.state != cvt_pkg::ST_IDLE;
    endsequence
    sequence s_quiet;
        st_r.state == cvt_pkg::ST_IDLE && !mic_clock_output && !serial_audio_oe;
    endsequence
    sequence s_enter_run;
        (st_r.state == cvt_pkg::ST_LOCK) ##1 run;
    endsequence

    a_loss_stops: assert property (s_lost |=> s_quiet) // [RULE5]
        else $error("clock loss did not idle");
    a_mic_run_only: assert property (!run |-> !mic_clock_output) // [RULE3]
        else $error("mic clock outside run");
    a_lock_count: assert property (s_enter_run |-> $past(st_r.lock_cnt) + 5'h01 == $past(need)) // [RULE3]
        else $error("wrong lock frame count");
    a_relock_short: assert property ((!st_r.first && st_r.state == cvt_pkg::ST_LOCK) ##1 run
        |-> $past(st_r.lock_cnt) == cvt_pkg::RELOCK_FRAMES - 5'h01) // [RULE6]
        else $error("relock frame count wrong");
    a_mute_load: assert property (s_enter_run |-> st_r.mute == cvt_pkg::MUTE_FRAMES) // [RULE4]
        else $error("mute not loaded");
    a_oe_live: assert property (serial_audio_oe |-> live) // [RULE16]
        else $error("output driven while muted");
    a_fmt_change: assert property (br && fs_rise && run && km != st_r.k && !lost
        |=> st_r.state == cvt_pkg::ST_LOCK && !mic_clock_output) // [RULE7]
        else $error("format change missed");
    a_mic_edge: assert property (run && $changed(mic_clock_output) |-> $past(br || bf)) // [RULE9]
        else $error("mic clock moved off bit edge");
    a_ch0_fall: assert property ($fell(mic_clock_output) && run |-> $stable(st_r.acc1)) // [RULE2]
        else $error("channel 1 took falling bit");
    a_slot_place: assert property (serial_audio_oe && !i2s
        |-> st_r.obit[9:8] == 2'h0 && st_r.obit[7:6] == pair) // [RULE14]
        else $error("data outside chosen slots");
    a_pad_zero: assert property (serial_audio_oe && st_r.obit[4:0] >= cvt_pkg::PAD_FIRST
        |-> !serial_audio_out) // [RULE23]
        else $error("pad bit not zero");
    a_i2s_half: assert property (serial_audio_oe && i2s |-> st_r.obit[9:5] == 5'h00) // [RULE17]
        else $error("I2S bit beyond half frame");
endmodule

// File: sim/host_link.sv
`timescale 1ns/100ps
module host_link (
    input logic run,
    input logic [9:0] ratio,
    input logic sd_wire,
    output logic bit_clock,
    output logic frame_sync,
    output logic [63:0] last_frame,
    output int frames
);
    logic [63:0] shift_r;
    int r;

    // Host side of the link; bit clock stands low while stopped.
    // Frame rate runs above the audio band to keep the run short.
    initial
    begin
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        shift_r = 64'h0;
        last_frame = 64'h0;
        frames = 0;
        #3;
        forever
        begin
            r = int'(ratio);
            if (!run)
            begin
                bit_clock = 1'b0;
                frame_sync = 1'b0;
                #40;
            end
            else
            begin
                for (int b = 0; b < r; b++)
                begin
                    frame_sync = (r == 64) ? (b >= 32) : (b == 0);
                    #40;
                    bit_clock = 1'b1;
                    shift_r = {shift_r[62:0], sd_wire};
                    if (b == 0)
                    begin
                        last_frame = shift_r;
                        frames++;
                    end
                    #40;
                    bit_clock = 1'b0;
                end
            end
        end
    end
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clock;
    logic sys_rst;
    logic mic_density_input = 1'b0;
    logic [2:0] slot_strap;
    logic run;
    logic [9:0] ratio;
    logic invert;
    logic bit_clock;
    logic frame_sync;
    logic mic_clock_output;
    logic serial_audio_out;
    logic serial_audio_oe;
    logic last_mic = 1'b0;
    logic [63:0] last_frame;
    int frames;
    int quiet;
    int num_errors;
    int comparisons;
    wire sd_wire;

    // Released line floats for the host
    assign sd_wire = serial_audio_oe ? serial_audio_out : 1'bz;

    pdm_tdm_converter dut_u (
        .clock(clock),
        .sys_rst(sys_rst),
        .bit_clock(bit_clock),
        .frame_sync(frame_sync),
        .mic_density_input(mic_density_input),
        .slot_strap(slot_strap),
        .mic_clock_output(mic_clock_output),
        .serial_audio_out(serial_audio_out),
        .serial_audio_oe(serial_audio_oe)
    );

    host_link host_u (
        .run(run),
        .ratio(ratio),
        .sd_wire(sd_wire),
        .bit_clock(bit_clock),
        .frame_sync(frame_sync),
        .last_frame(last_frame),
        .frames(frames)
    );

    // System clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Two mics on one line; garbage once the mic clock stands still
    always @(posedge clock)
    begin
        last_mic <= mic_clock_output;
        quiet <= (mic_clock_output === last_mic) ? quiet + 1 : 0;
        mic_density_input <= (quiet > 20) ? ~mic_density_input : mic_clock_output ^ invert;
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_rng(input int v, input int lo, input int hi);
        comparisons++;
        if (v < lo || v > hi)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h to %h", $time, v, lo, hi);
        end
    endtask

    // Sel 0 waits for a mic clock rise, sel 1 for the output enable
    task automatic wait_for(input int sel, input int bound);
        int n;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (n < bound && !((sel == 0) ? (mic_clock_output === 1'b1 && last_mic === 1'b0)
                                         : (serial_audio_oe === 1'b1)));
    endtask

    task automatic wait_quiet(input int bound, output int q);
        int n;
        n = 0;
        q = 0;
        while (q < 50 && n < bound)
        begin
            @(negedge clock);
            q = (mic_clock_output === 1'b0) ? q + 1 : 0;
            n++;
        end
    endtask

    task automatic wait_frames(input int k);
        int f;
        f = frames + k;
        while (frames < f)
            @(negedge clock);
    endtask

    task automatic mic_per_frame(output int n);
        int f;
        f = frames;
        while (frames == f)
            @(negedge clock);
        f = frames;
        n = 0;
        while (frames == f)
        begin
            @(negedge clock);
            if (mic_clock_output === 1'b1 && last_mic === 1'b0)
                n++;
        end
    endtask

    task automatic start_up();
        int f0;
        int fm;
        int n;
        f0 = frames;
        wait_for(0, 20 * 640);
        fm = frames;
        check_rng(fm - f0, 16, 18);
        mic_per_frame(n);
        check(64'(n), 64'h40);
        wait_for(1, 52 * 640);
        check_rng(frames - fm, 48, 50);
        wait_frames(6);
        check(last_frame, {24'h7FFFFF, 8'h00, 24'h800000, 8'h00});
    endtask

    task automatic format_change();
        int f0;
        int q;
        int n;
        @(posedge clock);
        ratio <= 10'h080;
        f0 = frames;
        wait_quiet(4 * 1280, q);
        check_rng(q, 50, 50);
        check_rng(frames - f0, 0, 3);
        wait_for(0, 10 * 1280);
        check_rng(frames - f0, 4, 8);
        mic_per_frame(n);
        check(64'(n), 64'h40);
    endtask

    task automatic clock_loss();
        int f0;
        int q;
        int n;
        @(posedge clock);
        run <= 1'b0;
        // Host ends its frame first, then the loss watchdog must run out
        wait_quiet(3 * 1280, q);
        check_rng(q, 50, 50);
        n = 0;
        repeat (600)
        begin
            @(negedge clock);
            if (mic_clock_output !== 1'b0 || serial_audio_oe !== 1'b0)
                n++;
        end
        check(64'(n), 64'h0);
        @(posedge clock);
        invert <= 1'b1;
        ratio <= 10'h040;
        run <= 1'b1;
        f0 = frames;
        wait_for(0, 10 * 640);
        check_rng(frames - f0, 3, 7);
        wait_for(1, 52 * 640);
        wait_frames(6);
        check(last_frame, {24'h800000, 8'h00, 24'h7FFFFF, 8'h00});
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        slot_strap = cvt_pkg::STRAP_I2S;
        run = 1'b0;
        ratio = 10'h040;
        invert = 1'b0;
        num_errors = 0;
        comparisons = 0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        run <= 1'b1;
        start_up();
        format_change();
        clock_loss();
        complete_run();
    end

    // Watchdog a little past the expected run of about 97k cycles
    initial
    begin
        repeat (104000) @(posedge clock);
        num_errors++;
        $display("MISMATCH at %0t: watchdog got %h expected %h", $time, 104000, 0);
        complete_run();
    end
endmodule
